// file: verilog/cseb_top.sv
// Purpose: Processor-side sideband logic: error/break pin, snoop stall, internal error, soft init.
// Assumes: One bus clock at 100 MHz; synchronous active-high reset from the core's reset path.
// Notes: Pins are active low; open-drain style pins use separate out and enable signals; the hit lines also have an in.
//
// Contract
// (RULE1) Without stop-clock, drive error/break pin low on an unmasked floating-point error.
// (RULE2) With stop-clock, drive it low for a pending break; hold until stop-clock leaves.
// (RULE3) Probe request during stop-clock counts as a break event.
// (RULE4) A snoop stall drives hit and hit-modified together; repeat both to extend.
// (RULE5) Internal error drives its pin low until reset, bus init or soft init.
// (RULE6) Internal error normally goes with a shutdown transaction request.
// (RULE7) Ignore-numeric-error lets pending float errors pass; otherwise raise an exception.
// (RULE8) Ignore-numeric-error is disregarded when the numeric-error enable bit is set.
// (RULE9) Other party makes ignore and soft-init valid by target-ready of the write.
// (RULE10) Soft init resets integer state only, then restarts at the reset vector; the code also clears the floating-point error latch.
// (RULE11) Snoop servicing continues throughout soft init.
// (RULE12) Soft init seen low at reset release starts the built-in self-test.
// (RULE13) On reset, all outputs go to idle within two bus clocks.
// (RULE14) All sideband pins are active low.
`timescale 1ns/10ps
`include "cseb_cfg.svh"
module cseb_top
	import cseb_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic stop_clock_request_n,
	input wire logic probe_request_n,
	input wire logic ignore_numeric_error_n,
	input wire logic soft_init_n,
	input wire logic bus_init_n,
	input wire logic snoop_hit_in_n,
	input wire logic snoop_hit_modified_in_n,
	input wire logic fp_unmasked_error,
	input wire logic fp_error_clear,
	input wire logic fp_noncontrol_issue,
	input wire logic numeric_error_enable,
	input wire logic break_event,
	input wire logic internal_error_event,
	input wire logic snoop_stall_request,
	input wire logic snoop_done,
	input wire logic self_test_done,
	output logic fp_error_break_out_n,
	output logic fp_error_break_oe,
	output logic snoop_hit_out_n,
	output logic snoop_hit_oe,
	output logic snoop_hit_modified_out_n,
	output logic snoop_hit_modified_oe,
	output logic internal_error_out_n,
	output logic shutdown_request,
	output logic fp_exception,
	output logic integer_reset,
	output logic restart_at_reset_vector,
	output logic self_test_run,
	output logic snoop_service_enable,
	output logic peer_snoop_stall
);
	////////////////////////////////////////////////////////////////////////////
	// Synchronised pins, active high after inversion.
	logic [`CSEB_NUM_ASYNC-1:0] pins_sync;
	cseb_sync #(.WIDTH(`CSEB_NUM_ASYNC)) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({snoop_hit_modified_in_n, snoop_hit_in_n, bus_init_n, soft_init_n,
			ignore_numeric_error_n, probe_request_n, stop_clock_request_n}),
		.sync_out(pins_sync)
	);

	function automatic logic pin_on(input logic level);
		pin_on = (level == `CSEB_PIN_ASSERTED); // [RULE14]
	endfunction

	logic stop_clk;
	logic probe;
	logic ignore_ne;
	logic init_act;
	logic bus_init_act;
	assign stop_clk = pin_on(pins_sync[`CSEB_IN_STOP_CLOCK]);
	assign probe = pin_on(pins_sync[`CSEB_IN_PROBE]);
	assign ignore_ne = pin_on(pins_sync[`CSEB_IN_IGNORE_NE]); // [RULE9]
	assign init_act = pin_on(pins_sync[`CSEB_IN_SOFT_INIT]); // [RULE9]
	assign bus_init_act = pin_on(pins_sync[`CSEB_IN_BUS_INIT]);

	////////////////////////////////////////////////////////////////////////////
	// Floating-point error and pending break share one pin.
	logic fp_err_q;
	logic break_q;
	always_ff @(posedge clk) begin
		if (reset || init_act) begin
			fp_err_q <= 1'b0;
		end else if (fp_unmasked_error) begin
			fp_err_q <= 1'b1; // Set wins over a same-cycle clear.
		end else if (fp_error_clear) begin
			fp_err_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !stop_clk) begin
			break_q <= 1'b0; // [RULE2]
		end else if (break_event || probe) begin
			break_q <= 1'b1; // [RULE2] [RULE3]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fp_error_break_out_n <= `CSEB_PIN_IDLE; // [RULE13]
			fp_error_break_oe <= 1'b0;
		end else begin
			// Meaning follows stop-clock: error outside it, break inside it.
			fp_error_break_out_n <= stop_clk ? ~break_q : ~fp_err_q; // [RULE1] [RULE2]
			fp_error_break_oe <= stop_clk ? break_q : fp_err_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Numeric error handling for noncontrol instructions.
	always_ff @(posedge clk) begin
		if (reset) begin
			fp_exception <= 1'b0;
		end else begin
			// With the enable bit set the pin is of no account. [RULE8]
			fp_exception <= fp_noncontrol_issue && fp_err_q &&
				(numeric_error_enable || !ignore_ne); // [RULE7] [RULE8]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Snoop stall: both lines always move together.
	always_ff @(posedge clk) begin
		if (reset) begin
			snoop_hit_out_n <= `CSEB_PIN_IDLE; // [RULE13]
			snoop_hit_modified_out_n <= `CSEB_PIN_IDLE;
			snoop_hit_oe <= 1'b0;
			snoop_hit_modified_oe <= 1'b0;
			peer_snoop_stall <= 1'b0;
		end else begin
			snoop_hit_out_n <= ~snoop_stall_request; // [RULE4]
			snoop_hit_modified_out_n <= ~snoop_stall_request; // [RULE4]
			snoop_hit_oe <= snoop_stall_request;
			snoop_hit_modified_oe <= snoop_stall_request;
			peer_snoop_stall <= pin_on(pins_sync[`CSEB_IN_HIT]) && pin_on(pins_sync[`CSEB_IN_SNOOP_HIT_MODIFIED]); // [RULE4]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Internal error is sticky until reset, bus init or soft init.
	logic internal_error_out_q;
	always_ff @(posedge clk) begin
		if (reset || bus_init_act || init_act) begin
			internal_error_out_q <= 1'b0; // [RULE5]
		end else if (internal_error_event) begin
			internal_error_out_q <= 1'b1; // [RULE5]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			internal_error_out_n <= `CSEB_PIN_IDLE; // [RULE13]
			shutdown_request <= 1'b0;
		end else begin
			internal_error_out_n <= ~internal_error_out_q; // [RULE5]
			// One pulse per new error; core logic may turn it into an NMI.
			shutdown_request <= internal_error_event && !internal_error_out_q; // [RULE6]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Soft init and self-test sequencing.
	cseb_state_t state_q;
	// The pin bank is held idle in reset, so the level at release reaches logic two edges later.
	logic [2:0] reset_seen_q;
	logic init_edge_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_seen_q <= 3'h1;
			init_edge_q <= 1'b0;
		end else begin
			reset_seen_q <= {reset_seen_q[1:0], 1'b0};
			init_edge_q <= init_act;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= CSEB_RUN;
		end else begin
			case (state_q)
				CSEB_RUN: begin
					if (reset_seen_q[2] && init_act) begin
						state_q <= CSEB_SELF_TEST; // [RULE12]
					end else if (init_act) begin
						state_q <= CSEB_SOFT_INIT; // [RULE10]
					end
				end
				CSEB_SOFT_INIT: begin
					if (!init_act) begin
						state_q <= CSEB_RUN;
					end
				end
				CSEB_SELF_TEST: begin
					if (self_test_done) begin
						state_q <= CSEB_RUN;
					end
				end
				default: state_q <= CSEB_RUN;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			integer_reset <= 1'b0;
			restart_at_reset_vector <= 1'b0;
			self_test_run <= 1'b0;
			snoop_service_enable <= 1'b0;
		end else begin
			integer_reset <= (state_q == CSEB_SOFT_INIT); // [RULE10]
			// Restart pulses once when soft init is released.
			restart_at_reset_vector <= (state_q == CSEB_SOFT_INIT) && !init_act && init_edge_q; // [RULE10]
			self_test_run <= (state_q == CSEB_SELF_TEST); // [RULE12]
			snoop_service_enable <= (state_q != CSEB_SELF_TEST); // [RULE11]
		end
	end
endmodule // cseb_top

// file: verilog/cseb_cfg.svh
// Purpose: Constants for the processor sideband error and init block.
// Assumes: Bus clock at 100 MHz; all sideband pins active low.
// Notes: Bit positions index the core-side request vectors.
`ifndef CSEB_CFG_SVH
`define CSEB_CFG_SVH
`define CSEB_RELEASE_CLOCKS 2
`define CSEB_PIN_ASSERTED 1'h0
`define CSEB_PIN_IDLE 1'h1
`define CSEB_SYNC_RESET_VAL 1'h1
`define CSEB_NUM_ASYNC 7
`define CSEB_IN_STOP_CLOCK 0
`define CSEB_IN_PROBE 1
`define CSEB_IN_IGNORE_NE 2
`define CSEB_IN_SOFT_INIT 3
`define CSEB_IN_BUS_INIT 4
`define CSEB_IN_HIT 5
`define CSEB_IN_SNOOP_HIT_MODIFIED 6
`endif

// file: verilog/cseb_pkg.sv
// Purpose: Types for the processor sideband error and init block.
// Assumes: Included constants come from cseb_cfg.svh.
// Notes: State codes are binary and written out.
package cseb_pkg;
	typedef enum logic [1:0] {
		CSEB_RUN = 2'b00,
		CSEB_SOFT_INIT = 2'b01,
		CSEB_SELF_TEST = 2'b10
	} cseb_state_t;
endpackage

// file: verilog/cseb_sync.sv
// Purpose: Two-flop synchroniser bank for the asynchronous sideband pins.
// Assumes: Pins idle high; reset is synchronous and active high.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`include "cseb_cfg.svh"
module cseb_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) begin
			$error("cseb_sync needs WIDTH of at least one");
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= {WIDTH{`CSEB_SYNC_RESET_VAL}};
			sync_out <= {WIDTH{`CSEB_SYNC_RESET_VAL}};
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // cseb_sync

// file: test/cseb_checker.sv
// Purpose: Assertions on the sideband block's ports.
// Assumes: Pins active low, seen by logic two edges late.
// Notes: Histories skip checks near a recent pin change.
`timescale 1ns/10ps
module cseb_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic stop_clock_request_n,
	input wire logic probe_request_n,
	input wire logic ignore_numeric_error_n,
	input wire logic soft_init_n,
	input wire logic bus_init_n,
	input wire logic fp_unmasked_error,
	input wire logic fp_noncontrol_issue,
	input wire logic numeric_error_enable,
	input wire logic break_event,
	input wire logic internal_error_event,
	input wire logic snoop_stall_request,
	input logic fp_error_break_out_n,
	input logic fp_error_break_oe,
	input logic snoop_hit_out_n,
	input logic snoop_hit_oe,
	input logic snoop_hit_modified_out_n,
	input logic snoop_hit_modified_oe,
	input logic internal_error_out_n,
	input logic shutdown_request,
	input logic fp_exception
);
	logic [2:0] sc_h, pr_h, ig_h, q_h;
	always_ff @(posedge clk) begin
		sc_h <= {sc_h[1:0], stop_clock_request_n};
		pr_h <= {pr_h[1:0], probe_request_n};
		ig_h <= {ig_h[1:0], ignore_numeric_error_n};
		q_h <= {q_h[1:0], bus_init_n & soft_init_n};
	end
	wire sc_hi = stop_clock_request_n && (&sc_h);
	wire sc_lo = !stop_clock_request_n && !(|sc_h);
	wire quiet = bus_init_n && soft_init_n && (&q_h);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	property p_stall; snoop_stall_request |=> !snoop_hit_out_n && snoop_hit_oe; endproperty
	a_stall: assert property (p_stall) else $error("stall missing");
	property p_pair; snoop_hit_out_n == snoop_hit_modified_out_n && snoop_hit_oe == snoop_hit_modified_oe; endproperty
	a_pair: assert property (p_pair) else $error("hit lines differ");
	property p_internal_error_out; internal_error_event && quiet |=> ##1 !internal_error_out_n; endproperty
	a_internal_error_out: assert property (p_internal_error_out) else $error("internal_error_out missing");
	property p_hold; !internal_error_out_n && quiet |=> !internal_error_out_n; endproperty
	a_hold: assert property (p_hold) else $error("internal_error_out dropped");
	property p_shut; shutdown_request && quiet |=> !internal_error_out_n; endproperty
	a_shut: assert property (p_shut) else $error("shutdown alone");
	property p_fp; fp_unmasked_error && sc_hi && soft_init_n |=> ##1 !fp_error_break_out_n && fp_error_break_oe; endproperty
	a_fp: assert property (p_fp) else $error("fp error missing");
	property p_brk; break_event && sc_lo |=> ##1 (!fp_error_break_out_n)[*3]; endproperty
	a_brk: assert property (p_brk) else $error("break not held");
	property p_probe; !probe_request_n && !(|pr_h) && sc_lo |-> ##[0:2] !fp_error_break_out_n; endproperty
	a_probe: assert property (p_probe) else $error("probe ignored");
	property p_ne; fp_noncontrol_issue && numeric_error_enable && sc_hi && !fp_error_break_out_n |=> fp_exception; endproperty
	a_ne: assert property (p_ne) else $error("ignore not disregarded");
	property p_ign; fp_noncontrol_issue && !numeric_error_enable && !(|ig_h) && !ignore_numeric_error_n |=> !fp_exception;
	endproperty
	a_ign: assert property (p_ign) else $error("ignore not honoured");
	property p_rst; disable iff (1'h0) reset |=> fp_error_break_out_n && !fp_error_break_oe && !snoop_hit_oe; endproperty
	a_rst: assert property (p_rst) else $error("outputs busy in reset");
	c_stall: cover property (snoop_stall_request);
	c_brk: cover property (break_event && sc_lo);
	c_shut: cover property (shutdown_request);
endmodule // cseb_checker
bind cseb_top cseb_checker u_cseb_checker (.*);

// file: test/cseb_chipset.sv
// Purpose: Core logic model driving the sideband pins.
// Assumes: cmd bits, high to assert: stop, probe, ignore, init, bus init.
// Notes: Pins change only on clock edges.
`timescale 1ns/10ps
module cseb_chipset (
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] cmd,
	input wire logic stall,
	output logic stop_clock_request_n,
	output logic probe_request_n,
	output logic ignore_numeric_error_n,
	output logic soft_init_n,
	output logic bus_init_n,
	output logic snoop_hit_in_n,
	output logic snoop_hit_modified_in_n
);
	// Init is not released in reset, so a self-test request can span it.
	always_ff @(posedge clk) begin
		{bus_init_n, soft_init_n, ignore_numeric_error_n, probe_request_n, stop_clock_request_n} <= ~cmd;
	end
	always_ff @(posedge clk) begin
		snoop_hit_in_n <= reset | ~stall;
		snoop_hit_modified_in_n <= reset | ~stall;
	end
endmodule // cseb_chipset

// file: test/cpu_sideband_error_init_bench.sv
// Purpose: Scenario bench for the sideband block.
// Assumes: 100 MHz clock; reset held 12 cycles.
// Notes: Waits cover the two-flop pin latency.
`timescale 1ns/10ps
module cpu_sideband_error_init_bench;
	logic clk = 1'h0, reset = 1'h1, fp_unmasked_error = 1'h0, fp_error_clear = 1'h0, fp_noncontrol_issue = 1'h0;
	logic numeric_error_enable = 1'h0, break_event = 1'h0, internal_error_event = 1'h0, snoop_stall_request = 1'h0;
	logic snoop_done = 1'h0, self_test_done = 1'h0, stall = 1'h0;
	logic [4:0] cmd = 5'h00;
	logic stop_clock_request_n, probe_request_n, ignore_numeric_error_n, soft_init_n, bus_init_n, snoop_hit_in_n;
	logic snoop_hit_modified_in_n, fp_error_break_out_n, fp_error_break_oe, snoop_hit_out_n, snoop_hit_oe;
	logic snoop_hit_modified_out_n, snoop_hit_modified_oe, internal_error_out_n, shutdown_request, fp_exception;
	logic integer_reset, restart_at_reset_vector, self_test_run, snoop_service_enable, peer_snoop_stall;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	cseb_top u_cseb_top (.*);
	cseb_chipset u_cseb_chipset (.*);
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task finish_test;
		if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task t_stall;
		@(posedge clk) snoop_stall_request <= 1'h1;
		@(posedge clk) snoop_stall_request <= 1'h0;
		#1 chk({snoop_hit_out_n, snoop_hit_modified_out_n, snoop_hit_oe}, 8'h01);
		@(posedge clk) stall <= 1'h1;
		w(5);
		chk(peer_snoop_stall, 8'h01);
		@(posedge clk) stall <= 1'h0;
	endtask
	task t_internal_error_out;
		for (int i = 3; i < 5; i++) begin
			@(posedge clk) internal_error_event <= 1'h1;
			@(posedge clk) internal_error_event <= 1'h0;
			#1 chk(shutdown_request, 8'h01);
			w(6);
			chk(internal_error_out_n, 8'h00);
			@(posedge clk) cmd[i] <= 1'h1;
			w(6);
			chk(internal_error_out_n, 8'h01);
			if (i == 3) chk({integer_reset, snoop_service_enable}, 8'h03);
			@(posedge clk) cmd[i] <= 1'h0;
			w(4);
			chk(restart_at_reset_vector, 8'(i == 3));
			w(2);
		end
	endtask
	task t_fp;
		@(posedge clk) fp_unmasked_error <= 1'h1;
		@(posedge clk) fp_unmasked_error <= 1'h0;
		w(1);
		chk({fp_error_break_out_n, fp_error_break_oe}, 8'h01);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) cmd[2] <= (i != 0);
			numeric_error_enable <= i[1];
			w(5);
			@(posedge clk) fp_noncontrol_issue <= 1'h1;
			@(posedge clk) fp_noncontrol_issue <= 1'h0;
			#1 chk(fp_exception, 8'(i != 1));
		end
		@(posedge clk) fp_error_clear <= 1'h1;
		cmd[2] <= 1'h0;
		@(posedge clk) fp_error_clear <= 1'h0;
		w(2);
		chk(fp_error_break_out_n, 8'h01);
	endtask
	task t_brk;
		@(posedge clk) cmd[0] <= 1'h1;
		w(5);
		chk(fp_error_break_out_n, 8'h01);
		@(posedge clk) break_event <= 1'h1;
		@(posedge clk) break_event <= 1'h0;
		w(6);
		chk(fp_error_break_out_n, 8'h00);
		@(posedge clk) cmd[0] <= 1'h0;
		w(6);
		chk(fp_error_break_out_n, 8'h01);
		@(posedge clk) cmd[1:0] <= 2'h3;
		w(6);
		chk(fp_error_break_out_n, 8'h00);
		@(posedge clk) cmd[1:0] <= 2'h0;
		w(6);
	endtask
	task t_built_in_self_test;
		@(posedge clk) cmd[3] <= 1'h1;
		reset <= 1'h1;
		w(3);
		@(posedge clk) reset <= 1'h0;
		w(4);
		chk({self_test_run, snoop_service_enable}, 8'h02);
		@(posedge clk) cmd[3] <= 1'h0;
		self_test_done <= 1'h1;
		@(posedge clk) self_test_done <= 1'h0;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'h0;
		t_stall;
		t_internal_error_out;
		t_fp;
		t_brk;
		t_built_in_self_test;
		finish_test;
	end
endmodule // cpu_sideband_error_init_bench
